// *** verilog/interrupt_enable_mask.sv ***
// Our own choices: the register offsets and the Avalon-MM slave port.
`timescale 1ns/10ps
// Operation
// - Bit 31 gates abort button interrupt
// - Bit 30 gates mains loss interrupt
// - Bit 29 gates bus grant timeout
// - Bit 26 gates depth board interrupt
// - Bit 25 gates video controller interrupt
// - Bit 24 gates memory check error
// - Bits 23,19,14 gate VME levels 7,6,5
// - Bits 12,10,6,4 gate VME levels 4-1
// - Bit 22 gates keyboard interrupt
// - Bit 21 gates counter IO chip
// - Bit 20 gates bus failure interrupt
// - Bit 18 gates printer port interrupt
// - Bits 17,16 gate serial pairs A,B
// - Bit 15 gates LAN controller interrupt
// - Bit 13 gates DMA count done
// - Bit 11 gates DMA protect fault
// - Bit 9 gates DMA valid flag
// - Bit 5 gates disk bus controller
// - Bits 1,0 gate soft interrupts
// - System reset clears; local reset keeps
// - First register CPU0, second CPU1
// - Enable bits mirror status bit positions
module interrupt_enable_mask #(
  parameter int NUM_CPUS = irq_enable_pkg::NUM_CPUS
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic local_reset_i,
  input wire logic [irq_enable_pkg::ADDR_WIDTH-1:0] avs_address_i,
  input wire logic avs_read_i,
  input wire logic avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic [3:0] avs_byteenable_i,
  output logic [31:0] avs_readdata_o,
  output logic avs_waitrequest_o,
  input wire logic [31:0] source_req_i,
  output logic [NUM_CPUS-1:0] cpu_irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // Bus slave

  typedef enum logic [1:0] {
    bus_idle,
    bus_answer
  } bus_state_type;

  bus_state_type bus_state;
  logic [31:0] cpu_zero_irq_enable;
  logic [31:0] cpu_one_irq_enable;
  logic [31:0] irq_status_reg;
  logic [31:0] config_reg;
  logic [31:0] pending [NUM_CPUS];
  logic [31:0] enable_vec [NUM_CPUS];
  logic [31:0] byte_mask;
  logic [31:0] next_readdata;
  logic bus_req;
  logic bus_take;

  function automatic logic [31:0] lane_mask(input logic [3:0] be);
    lane_mask = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
  endfunction

  function automatic logic [31:0] merge_word(input logic [31:0] old_value, input logic [31:0] new_value,
                                             input logic [31:0] mask);
    merge_word = ((old_value & ~mask) | (new_value & mask)) & irq_enable_pkg::SOURCE_MASK;
  endfunction

  assign bus_req = avs_read_i | avs_write_i;
  // One wait cycle: the request is taken when the slave sits in answer
  assign bus_take = bus_req && (bus_state == bus_answer);
  assign avs_waitrequest_o = ~bus_take;
  assign byte_mask = lane_mask(avs_byteenable_i);

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      bus_state <= bus_idle;
    end else begin
      case (bus_state)
        bus_idle: begin
          if (bus_req) begin
            bus_state <= bus_answer;
          end
        end
        bus_answer: begin
          bus_state <= bus_idle;
        end
        default: begin
          bus_state <= bus_idle;
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Enable registers

  // Local reset has no effect here; only system reset clears
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cpu_zero_irq_enable <= irq_enable_pkg::ENABLE_RESET;
    end else if (bus_take && avs_write_i && avs_address_i == irq_enable_pkg::CPU_ZERO_ENABLE_IDX) begin
      // Reserved bits are dropped even if software breaks the zero-write
      cpu_zero_irq_enable <= merge_word(cpu_zero_irq_enable, avs_writedata_i, byte_mask);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      cpu_one_irq_enable <= irq_enable_pkg::ENABLE_RESET;
    end else if (bus_take && avs_write_i && avs_address_i == irq_enable_pkg::CPU_ONE_ENABLE_IDX) begin
      cpu_one_irq_enable <= merge_word(cpu_one_irq_enable, avs_writedata_i, byte_mask);
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      config_reg <= irq_enable_pkg::CONFIG_RESET;
    end else if (bus_take && avs_write_i && avs_address_i == irq_enable_pkg::CONFIG_IDX) begin
      config_reg <= ((config_reg & ~byte_mask) | (avs_writedata_i & byte_mask)) & 32'h0000_0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Source capture

  // Hardware sources are levels; soft bits are set by writing status
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      irq_status_reg <= '0;
    end else begin
      irq_status_reg[31:2] <= source_req_i[31:2] & irq_enable_pkg::SOURCE_MASK[31:2];
      if (bus_take && avs_write_i && avs_address_i == irq_enable_pkg::STATUS_IDX && avs_byteenable_i[0]) begin
        irq_status_reg[1:0] <= avs_writedata_i[1:0] | source_req_i[1:0];
      end else begin
        irq_status_reg[1:0] <= irq_status_reg[1:0] | source_req_i[1:0];
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Per-CPU gating

  assign enable_vec[0] = cpu_zero_irq_enable;
  assign enable_vec[1] = cpu_one_irq_enable;

  // Bitwise gate covers every named field in its own position
  generate
    for (genvar cpu = 0; cpu < NUM_CPUS; cpu++) begin : g_cpu
      irq_gate #(
        .WIDTH(32)
      ) u_gate (
        .sys_clk_i(sys_clk_i),
        .reset_i(reset_i),
        .status_i(irq_status_reg),
        .enable_i(enable_vec[cpu]),
        .cpu_present_i((cpu == 0) ? 1'b1 : config_reg[irq_enable_pkg::CFG_DUAL_CPU_BIT]),
        .pending_o(pending[cpu]),
        .irq_o(cpu_irq_o[cpu])
      );
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Read data

  always_comb begin
    next_readdata = irq_enable_pkg::UNMAPPED_READ;
    case (avs_address_i)
      irq_enable_pkg::CPU_ZERO_ENABLE_IDX: begin
        next_readdata = cpu_zero_irq_enable;
      end
      irq_enable_pkg::CPU_ONE_ENABLE_IDX: begin
        next_readdata = cpu_one_irq_enable;
      end
      irq_enable_pkg::STATUS_IDX: begin
        next_readdata = irq_status_reg;
      end
      irq_enable_pkg::PENDING_IDX: begin
        next_readdata = pending[0] | pending[1];
      end
      irq_enable_pkg::CONFIG_IDX: begin
        next_readdata = config_reg;
      end
      default: begin
        next_readdata = irq_enable_pkg::UNMAPPED_READ;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      avs_readdata_o <= '0;
    end else if (bus_req && bus_state == bus_idle) begin
      avs_readdata_o <= next_readdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  a_reset_clears: assert property (@(posedge sys_clk_i)
    ##1 $past(reset_i) |-> cpu_zero_irq_enable == irq_enable_pkg::ENABLE_RESET
      && cpu_one_irq_enable == irq_enable_pkg::ENABLE_RESET)
    else $error("enable not cleared by system reset");
  a_local_keeps: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ##1 !$past(reset_i) && !$past(bus_take) |-> $stable(cpu_zero_irq_enable) && $stable(cpu_one_irq_enable))
    else $error("enable changed without a write");
  a_local_reset_ignored: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    local_reset_i && !bus_take |=> $stable(cpu_zero_irq_enable) && $stable(cpu_one_irq_enable))
    else $error("local reset disturbed an enable");
  a_reserved_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    (cpu_zero_irq_enable & ~irq_enable_pkg::SOURCE_MASK) == 32'h0
    && (cpu_one_irq_enable & ~irq_enable_pkg::SOURCE_MASK) == 32'h0)
    else $error("reserved enable bit set");
  a_write_zero: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    bus_take && avs_write_i && avs_address_i == irq_enable_pkg::CPU_ZERO_ENABLE_IDX && avs_byteenable_i == 4'hf
    |=> cpu_zero_irq_enable == ($past(avs_writedata_i) & irq_enable_pkg::SOURCE_MASK))
    else $error("cpu zero enable write lost");
  a_write_one: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    bus_take && avs_write_i && avs_address_i == irq_enable_pkg::CPU_ONE_ENABLE_IDX && avs_byteenable_i == 4'hf
    |=> cpu_one_irq_enable == ($past(avs_writedata_i) & irq_enable_pkg::SOURCE_MASK))
    else $error("cpu one enable write lost");
  a_abort_masked: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    !cpu_zero_irq_enable[31] && irq_status_reg[31] |=> !pending[0][31])
    else $error("masked abort reached cpu zero");
  a_vme7_passes: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    cpu_zero_irq_enable[23] && irq_status_reg[23] |=> cpu_irq_o[0])
    else $error("enabled level 7 did not interrupt");
  a_wait_one: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    bus_req && bus_state == bus_idle |-> avs_waitrequest_o ##1 (!bus_req || !avs_waitrequest_o))
    else $error("bus answer not after one wait cycle");
  a_status_follows: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ##1 !$past(reset_i) |-> irq_status_reg[31:2] == ($past(source_req_i[31:2]) & irq_enable_pkg::SOURCE_MASK[31:2]))
    else $error("status bit not at its source position");
  a_soft_sticky: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    irq_status_reg[1:0] != 2'h0 && !(bus_take && avs_write_i && avs_address_i == irq_enable_pkg::STATUS_IDX)
    |=> (irq_status_reg[1:0] & $past(irq_status_reg[1:0])) == $past(irq_status_reg[1:0]))
    else $error("soft request lost without a write");
  a_cpu_one_gate: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ##1 !$past(reset_i) |-> pending[1] == $past(irq_status_reg & cpu_one_irq_enable)
      && cpu_irq_o[1] == ($past(config_reg[irq_enable_pkg::CFG_DUAL_CPU_BIT]) && pending[1] != 32'h0))
    else $error("cpu one gate wrong");
  a_read_stands: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    avs_read_i && !avs_waitrequest_o |-> avs_readdata_o == $past(next_readdata))
    else $error("read data not standing at the answer");

  // Each enable bit gates only its own status bit towards cpu zero
  property p_field(int pos);
    @(posedge sys_clk_i) disable iff (reset_i)
      ##1 !$past(reset_i) |-> pending[0][pos] == $past(irq_status_reg[pos] && cpu_zero_irq_enable[pos])
        && (cpu_irq_o[0] || !pending[0][pos]);
  endproperty

  a_abort_gate: assert property (
    p_field(irq_enable_pkg::ABORT_BUTTON_BIT))
    else $error("abort gate wrong");
  a_mains_gate: assert property (
    p_field(irq_enable_pkg::MAINS_LOSS_BIT))
    else $error("mains loss gate wrong");
  a_grant_timeout_gate: assert property (
    p_field(irq_enable_pkg::BUS_GRANT_TIMEOUT_BIT))
    else $error("grant timeout gate wrong");
  a_depth_gate: assert property (
    p_field(irq_enable_pkg::DEPTH_BOARD_BIT))
    else $error("depth board gate wrong");
  a_video_gate: assert property (
    p_field(irq_enable_pkg::VIDEO_CTRL_BIT))
    else $error("video gate wrong");
  a_check_error_gate: assert property (
    p_field(irq_enable_pkg::MEMORY_CHECK_ERROR_BIT))
    else $error("memory check gate wrong");
  a_vme7_gate: assert property (
    p_field(irq_enable_pkg::VME_LEVEL7_BIT))
    else $error("level 7 gate wrong");
  a_vme6_gate: assert property (
    p_field(irq_enable_pkg::VME_LEVEL6_BIT))
    else $error("level 6 gate wrong");
  a_vme5_gate: assert property (
    p_field(irq_enable_pkg::VME_LEVEL5_BIT))
    else $error("level 5 gate wrong");
  a_vme4_gate: assert property (
    p_field(irq_enable_pkg::VME_LEVEL4_BIT))
    else $error("level 4 gate wrong");
  a_vme3_gate: assert property (
    p_field(irq_enable_pkg::VME_LEVEL3_BIT))
    else $error("level 3 gate wrong");
  a_vme2_gate: assert property (
    p_field(irq_enable_pkg::VME_LEVEL2_BIT))
    else $error("level 2 gate wrong");
  a_vme1_gate: assert property (
    p_field(irq_enable_pkg::VME_LEVEL1_BIT))
    else $error("level 1 gate wrong");
  a_keyboard_gate: assert property (
    p_field(irq_enable_pkg::KEYBOARD_BIT))
    else $error("keyboard gate wrong");
  a_counter_io_gate: assert property (
    p_field(irq_enable_pkg::COUNTER_IO_CHIP_BIT))
    else $error("counter chip gate wrong");
  a_bus_failure_gate: assert property (
    p_field(irq_enable_pkg::BUS_FAILURE_BIT))
    else $error("bus failure gate wrong");
  a_printer_gate: assert property (
    p_field(irq_enable_pkg::PRINTER_PORT_BIT))
    else $error("printer port gate wrong");
  a_serial_a_gate: assert property (
    p_field(irq_enable_pkg::SERIAL_PAIR_A_BIT))
    else $error("serial pair a gate wrong");
  a_serial_b_gate: assert property (
    p_field(irq_enable_pkg::SERIAL_PAIR_B_BIT))
    else $error("serial pair b gate wrong");
  a_lan_gate: assert property (
    p_field(irq_enable_pkg::LAN_CTRL_BIT))
    else $error("lan gate wrong");
  a_dma_done_gate: assert property (
    p_field(irq_enable_pkg::DMA_COUNT_DONE_BIT))
    else $error("dma count gate wrong");
  a_dma_protect_gate: assert property (
    p_field(irq_enable_pkg::DMA_PROTECT_FAULT_BIT))
    else $error("dma protect gate wrong");
  a_dma_valid_gate: assert property (
    p_field(irq_enable_pkg::DMA_VALID_FLAG_BIT))
    else $error("dma valid gate wrong");
  a_disk_bus_gate: assert property (
    p_field(irq_enable_pkg::DISK_BUS_CTRL_BIT))
    else $error("disk bus gate wrong");
  a_soft_one_gate: assert property (
    p_field(irq_enable_pkg::SOFT_IRQ_ONE_BIT))
    else $error("soft one gate wrong");
  a_soft_zero_gate: assert property (
    p_field(irq_enable_pkg::SOFT_IRQ_ZERO_BIT))
    else $error("soft zero gate wrong");

  c_cpu0_irq: cover property (@(posedge sys_clk_i) disable iff (reset_i) $rose(cpu_irq_o[0]));
  c_cpu1_irq: cover property (@(posedge sys_clk_i) disable iff (reset_i) $rose(cpu_irq_o[1]));
  c_enable_write: cover property (@(posedge sys_clk_i) disable iff (reset_i) bus_take && avs_write_i);
  c_masked_src: cover property (@(posedge sys_clk_i) disable iff (reset_i)
    irq_status_reg != 32'h0 && cpu_zero_irq_enable == 32'h0);
  c_soft_set: cover property (@(posedge sys_clk_i) disable iff (reset_i) $rose(irq_status_reg[1]));

endmodule

// *** verilog/irq_enable_pkg.sv ***
package irq_enable_pkg;

  localparam int DATA_WIDTH = 32;
  localparam int ADDR_WIDTH = 4;
  localparam int NUM_CPUS = 2;

  // Word offsets of the registers (byte address is four times this)
  localparam logic [3:0] CPU_ZERO_ENABLE_IDX = 4'h1;
  localparam logic [3:0] CPU_ONE_ENABLE_IDX = 4'h2;
  localparam logic [3:0] STATUS_IDX = 4'h3;
  localparam logic [3:0] PENDING_IDX = 4'h4;
  localparam logic [3:0] CONFIG_IDX = 4'h5;

  localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;

  // Field positions of the enable and status words
  localparam int ABORT_BUTTON_BIT = 31;
  localparam int MAINS_LOSS_BIT = 30;
  localparam int BUS_GRANT_TIMEOUT_BIT = 29;
  localparam int DEPTH_BOARD_BIT = 26;
  localparam int VIDEO_CTRL_BIT = 25;
  localparam int MEMORY_CHECK_ERROR_BIT = 24;
  localparam int VME_LEVEL7_BIT = 23;
  localparam int KEYBOARD_BIT = 22;
  localparam int COUNTER_IO_CHIP_BIT = 21;
  localparam int BUS_FAILURE_BIT = 20;
  localparam int VME_LEVEL6_BIT = 19;
  localparam int PRINTER_PORT_BIT = 18;
  localparam int SERIAL_PAIR_A_BIT = 17;
  localparam int SERIAL_PAIR_B_BIT = 16;
  localparam int LAN_CTRL_BIT = 15;
  localparam int VME_LEVEL5_BIT = 14;
  localparam int DMA_COUNT_DONE_BIT = 13;
  localparam int VME_LEVEL4_BIT = 12;
  localparam int DMA_PROTECT_FAULT_BIT = 11;
  localparam int VME_LEVEL3_BIT = 10;
  localparam int DMA_VALID_FLAG_BIT = 9;
  localparam int VME_LEVEL2_BIT = 6;
  localparam int DISK_BUS_CTRL_BIT = 5;
  localparam int VME_LEVEL1_BIT = 4;
  localparam int SOFT_IRQ_ONE_BIT = 1;
  localparam int SOFT_IRQ_ZERO_BIT = 0;

  // Implemented source bits; reserved pairs 28-27, 8-7, 3-2 are zero
  localparam logic [31:0] SOURCE_MASK = 32'he7ff_fe73;
  localparam logic [31:0] SOFT_IRQ_MASK = 32'h0000_0003;
  localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

  // Config register fields
  localparam int CFG_DUAL_CPU_BIT = 0;
  localparam logic [31:0] CONFIG_RESET = 32'h0000_0001;

endpackage

// *** verilog/irq_gate.sv ***
`timescale 1ns/10ps
module irq_gate #(
  parameter int WIDTH = 32
) (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [WIDTH-1:0] status_i,
  input wire logic [WIDTH-1:0] enable_i,
  input wire logic cpu_present_i,
  output logic [WIDTH-1:0] pending_o,
  output logic irq_o
);

  logic [WIDTH-1:0] next_pending;

  // Bitwise pairing keeps each enable on its own status bit
  always_comb begin
    next_pending = status_i & enable_i;
  end

  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      pending_o <= '0;
      irq_o <= 1'b0;
    end else begin
      pending_o <= next_pending;
      irq_o <= cpu_present_i & (|next_pending);
    end
  end

  a_irq_follows: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ##1 !$past(reset_i) |-> irq_o == ($past(cpu_present_i) && |($past(status_i) & $past(enable_i))))
    else $error("irq output does not match masked status");
  a_pending_and: assert property (@(posedge sys_clk_i) disable iff (reset_i)
    ##1 !$past(reset_i) |-> pending_o == ($past(status_i) & $past(enable_i)))
    else $error("pending bit not status and enable");

endmodule

// *** tb/source_model.sv ***
`timescale 1ns/10ps
// Peripheral request lines, registered like a real source flop
module source_model (
  input wire logic sys_clk_i,
  input wire logic reset_i,
  input wire logic [31:0] level_i,
  output logic [31:0] source_req_o
);
  // Request levels keep the status bit positions
  always_ff @(posedge sys_clk_i) begin
    if (reset_i) begin
      source_req_o <= 32'h0000_0000;
    end else begin
      source_req_o <= level_i;
    end
  end
endmodule

// *** tb/interrupt_enable_mask_tb.sv ***
`timescale 1ns/10ps
module interrupt_enable_mask_tb;
  logic sys_clk_i = 1'b0;
  logic reset_i = 1'b1;
  logic local_reset_i = 1'b0;
  logic [irq_enable_pkg::ADDR_WIDTH-1:0] avs_address = 4'h0;
  logic avs_read = 1'b0;
  logic avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0000_0000;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic [31:0] level = 32'h0000_0000;
  logic [31:0] source_req;
  logic [1:0] cpu_irq;
  int error_cnt = 0;
  int compares = 0;
  int cycles = 0;

  interrupt_enable_mask dut (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .local_reset_i(local_reset_i),
    .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
    .avs_writedata_i(avs_writedata), .avs_byteenable_i(avs_byteenable), .avs_readdata_o(avs_readdata),
    .avs_waitrequest_o(avs_waitrequest), .source_req_i(source_req), .cpu_irq_o(cpu_irq));
  source_model partner (.sys_clk_i(sys_clk_i), .reset_i(reset_i), .level_i(level), .source_req_o(source_req));

  initial begin
    forever #2 sys_clk_i = ~sys_clk_i;
  end

  //////////////////////////////////////////////////////////////////////////////
  task results();
    $display("errors=%0d compares=%0d", error_cnt, compares);
    if (error_cnt == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  always @(posedge sys_clk_i) begin
    cycles++;
    if (cycles == 8000) begin
      error_cnt++;
      results();
    end
  end

  task check_word(input logic [31:0] exp, input logic [31:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, got);
    end
  endtask

  task check_irq(input logic [1:0] exp);
    compares++;
    if (cpu_irq !== exp) begin
      error_cnt++;
      $display("[FAIL] t=%0t exp=%h got=%h", $time, exp, cpu_irq);
    end
  endtask

  // Request held until waitrequest is sampled low
  task bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b, output logic [31:0] q);
    @(posedge sys_clk_i);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= b;
    avs_write <= w;
    avs_read <= ~w;
    do begin
      @(posedge sys_clk_i);
    end while (avs_waitrequest !== 1'b0);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
  endtask

  task wr(input logic [3:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, 4'hf, q);
  endtask

  task rd_chk(input logic [3:0] a, input logic [31:0] exp);
    logic [31:0] q;
    bus(1'b0, a, 32'h0000_0000, 4'hf, q);
    check_word(exp, q);
  endtask

  // Drive sources, then let model, status and irq stages settle
  task drive(input logic [31:0] v);
    @(posedge sys_clk_i);
    level <= v;
    repeat (5) @(posedge sys_clk_i);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  task t_reset();
    rd_chk(irq_enable_pkg::CPU_ZERO_ENABLE_IDX, irq_enable_pkg::ENABLE_RESET);
    rd_chk(irq_enable_pkg::CPU_ONE_ENABLE_IDX, irq_enable_pkg::ENABLE_RESET);
    rd_chk(irq_enable_pkg::CONFIG_IDX, irq_enable_pkg::CONFIG_RESET);
    check_irq(2'h0);
  endtask

  task t_reserved();
    logic [31:0] q;
    wr(irq_enable_pkg::CPU_ZERO_ENABLE_IDX, 32'hffff_ffff);
    rd_chk(irq_enable_pkg::CPU_ZERO_ENABLE_IDX, irq_enable_pkg::SOURCE_MASK);
    bus(1'b1, irq_enable_pkg::CPU_ONE_ENABLE_IDX, 32'hffff_ffff, 4'h2, q);
    rd_chk(irq_enable_pkg::CPU_ONE_ENABLE_IDX, 32'h0000_fe00);
  endtask

  // Each source alone: enabled towards cpu 0, masked towards cpu 1
  task t_bits();
    logic [31:0] b;
    for (int j = 0; j < 32; j++) begin
      b = 32'h0000_0001 << j;
      if ((irq_enable_pkg::SOURCE_MASK & b) != 32'h0000_0000) begin
        drive(32'h0000_0000);
        wr(irq_enable_pkg::STATUS_IDX, 32'h0000_0000);
        wr(irq_enable_pkg::CPU_ZERO_ENABLE_IDX, b);
        wr(irq_enable_pkg::CPU_ONE_ENABLE_IDX, irq_enable_pkg::SOURCE_MASK & ~b);
        drive(b);
        check_irq(2'h1);
        rd_chk(irq_enable_pkg::STATUS_IDX, b);
        rd_chk(irq_enable_pkg::PENDING_IDX, b);
        drive(32'h0000_0000);
        wr(irq_enable_pkg::STATUS_IDX, 32'h0000_0000);
        drive(32'h0000_0000);
        check_irq(2'h0);
      end
    end
    wr(irq_enable_pkg::CPU_ZERO_ENABLE_IDX, 32'h0000_0000);
  endtask

  task t_cpu();
    wr(irq_enable_pkg::CONFIG_IDX, 32'h0000_0000);
    wr(irq_enable_pkg::CPU_ONE_ENABLE_IDX, irq_enable_pkg::SOURCE_MASK);
    drive(32'h0000_0010);
    check_irq(2'h0);
    wr(irq_enable_pkg::CONFIG_IDX, 32'h0000_0001);
    drive(32'h0000_0010);
    check_irq(2'h2);
    rd_chk(irq_enable_pkg::PENDING_IDX, 32'h0000_0010);
    drive(32'h0000_0000);
  endtask

  // Software raises soft source one; it stays until written back to zero
  task t_soft();
    logic [31:0] s;
    s = 32'h0000_0001 << irq_enable_pkg::SOFT_IRQ_ONE_BIT;
    wr(irq_enable_pkg::CPU_ZERO_ENABLE_IDX, irq_enable_pkg::SOFT_IRQ_MASK);
    wr(irq_enable_pkg::STATUS_IDX, s);
    drive(32'h0000_0000);
    rd_chk(irq_enable_pkg::STATUS_IDX, s);
    rd_chk(irq_enable_pkg::PENDING_IDX, s);
    check_irq(2'h3);
    wr(irq_enable_pkg::STATUS_IDX, 32'h0000_0000);
    drive(32'h0000_0000);
    check_irq(2'h0);
  endtask

  task t_resets();
    wr(irq_enable_pkg::CPU_ZERO_ENABLE_IDX, 32'h8000_0001);
    @(posedge sys_clk_i);
    local_reset_i <= 1'b1;
    repeat (3) @(posedge sys_clk_i);
    local_reset_i <= 1'b0;
    rd_chk(irq_enable_pkg::CPU_ZERO_ENABLE_IDX, 32'h8000_0001);
    @(posedge sys_clk_i);
    reset_i <= 1'b1;
    repeat (2) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    rd_chk(irq_enable_pkg::CPU_ZERO_ENABLE_IDX, irq_enable_pkg::ENABLE_RESET);
    rd_chk(irq_enable_pkg::CPU_ONE_ENABLE_IDX, irq_enable_pkg::ENABLE_RESET);
  endtask

  task t_unmapped();
    wr(4'h0, 32'hffff_ffff);
    rd_chk(4'h0, irq_enable_pkg::UNMAPPED_READ);
    rd_chk(4'hf, irq_enable_pkg::UNMAPPED_READ);
  endtask

  //////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (16) @(posedge sys_clk_i);
    reset_i <= 1'b0;
    t_reset();
    t_reserved();
    t_bits();
    t_cpu();
    t_soft();
    t_unmapped();
    t_resets();
    results();
  end
endmodule
